// file: src/eepc_eeprom_program_erase_control.sv
// Decided for this implementation: the APB slave port and the placing of the registers.
module eepc_eeprom_program_erase_control
  import eepc_pkg::*;
#(
  parameter int unsigned AUTO_CYCLES = AUTO_CYCLES_DEF
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire eepc_apb_req_s apb_req,
  output eepc_apb_rsp_s      apb_rsp,
  // power modes from the core
  input  wire logic          wait_mode,
  input  wire logic          stop_mode,
  // analog control
  output logic               charge_pump_on
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [ARRAY_BYTES-1:0][7:0] mem;
    logic [7:0]                  nvr;
    eepc_ctl_s                   ctl;
    logic [7:0]                  shadow;
    logic                        load_pend;
    logic [IDX_W-1:0]            lat_addr;
    logic [7:0]                  lat_data;
    logic                        lat_valid;
    eepc_seq_e                   seq;
    logic [31:0]                 cnt;
    logic                        fail;
    logic                        busy;
    logic                        stop_d;
    logic                        pump_on;
    eepc_apb_rsp_s               rsp;
  } eepc_state_s;

  eepc_state_s st_reg;
  eepc_state_s st_next;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic in_array(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_ARRAY_LO) && (idx <= IDX_ARRAY_HI);
  endfunction

  function automatic logic [1:0] block_of(input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] off;
    off = idx - IDX_ARRAY_LO;
    return off[BLOCK_SHIFT+1:BLOCK_SHIFT];
  endfunction

  function automatic logic valid_target(input logic [IDX_W-1:0] idx);
    return in_array(idx) || (idx == IDX_NVR);
  endfunction

  function automatic logic op_allowed(input logic [IDX_W-1:0] idx,
                                      input logic [1:0]       mode,
                                      input logic [7:0]       shadow);
    logic secure;
    secure = !shadow[SHADOW_SECURE];
    if (secure && (mode == MODE_BLOCK_ERASE || mode == MODE_BULK_ERASE)) begin
      return 1'b0;
    end else if (idx == IDX_NVR) begin
      return !secure;
    end else if (secure && idx >= IDX_SEC_LO && idx <= IDX_SEC_HI) begin
      return 1'b0;
    end else begin
      return !shadow[block_of(idx)];
    end
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  logic [IDX_W-1:0] idx;
  logic             access;
  logic             apply;
  eepc_ctl_s        wctl;
  logic [IDX_W-1:0] off;

  assign idx    = apb_req.paddr[PADDR_W-1:2];
  assign access = apb_req.psel && apb_req.penable && !st_reg.rsp.pready;
  assign wctl   = eepc_ctl_s'(apb_req.pwdata[7:0]);

  always_comb begin
    st_next             = st_reg;
    st_next.rsp.pready  = 1'b0;
    st_next.rsp.pslverr = 1'b0;
    st_next.stop_d      = stop_mode;
    apply               = 1'b0;
    off                 = '0;

    // shadow of the config byte follows it after reset and after a read
    if (st_reg.load_pend) begin
      st_next.shadow    = st_reg.nvr;
      st_next.load_pend = 1'b0;
    end

    // wait_mode is deliberately not looked at: the sequence runs on
    case (st_reg.seq)
      SEQ_RUN: begin
        if (stop_mode && !st_reg.stop_d) begin
          st_next.seq     = SEQ_HALT;
          st_next.pump_on = 1'b0;
        end else begin
          st_next.cnt = st_reg.cnt + 32'h1;
          if (st_reg.ctl.auto_term && st_reg.cnt >= AUTO_CYCLES - 1) begin
            st_next.ctl.hv_apply = 1'b0;
            st_next.seq          = SEQ_IDLE;
            st_next.pump_on      = 1'b0;
            st_next.busy         = 1'b0;
            apply                = 1'b1;
          end
        end
      end
      SEQ_HALT: begin
        if (!stop_mode) begin
          st_next.seq     = SEQ_RUN;
          st_next.cnt     = '0;
          st_next.pump_on = 1'b1;
          st_next.busy    = 1'b1;
        end
      end
      default: begin
        if (stop_mode && !st_reg.stop_d && st_reg.ctl.bus_latch_ctl) begin
          st_next.lat_valid = 1'b0;
        end
      end
    endcase

    // ************************************************************
    // apb access
    // ************************************************************
    if (access) begin
      st_next.rsp.pready = 1'b1;
      st_next.rsp.prdata = '0;
      if (idx == IDX_CTL) begin
        if (!apb_req.pwrite) begin
          st_next.rsp.prdata = {24'h000000, st_reg.ctl};
        end else if (!st_reg.ctl.bus_latch_ctl || st_reg.lat_valid) begin
          st_next.ctl.spare_bit       = wctl.spare_bit;
          st_next.ctl.array_power_off = wctl.array_power_off;
          st_next.ctl.auto_term       = wctl.auto_term;
          if (!st_reg.ctl.hv_apply) begin
            st_next.ctl.erase_mode_sel = wctl.erase_mode_sel;
          end
          st_next.ctl.bus_latch_ctl = wctl.bus_latch_ctl || st_reg.ctl.hv_apply;
          if (!wctl.bus_latch_ctl && !st_reg.ctl.hv_apply) begin
            st_next.lat_valid = 1'b0;
          end
          if (wctl.hv_apply && !st_reg.ctl.hv_apply) begin
            if (st_reg.ctl.bus_latch_ctl && st_reg.lat_valid) begin
              st_next.ctl.hv_apply = 1'b1;
              st_next.seq          = SEQ_RUN;
              st_next.cnt          = '0;
              st_next.pump_on      = 1'b1;
              st_next.fail         = 1'b0;
            end
          end else if (!wctl.hv_apply && st_reg.ctl.hv_apply) begin
            st_next.ctl.hv_apply = 1'b0;
            st_next.seq          = SEQ_IDLE;
            st_next.pump_on      = 1'b0;
            st_next.busy         = 1'b0;
            apply                = (st_reg.seq == SEQ_RUN);
          end
        end
      end else if (valid_target(idx)) begin
        if (st_reg.busy || st_reg.seq == SEQ_HALT) begin
          st_next.rsp.pslverr = 1'b1;
        end else if (apb_req.pwrite) begin
          if (st_reg.ctl.bus_latch_ctl && !st_reg.ctl.hv_apply) begin
            st_next.lat_addr  = idx;
            st_next.lat_data  = apb_req.pwdata[7:0];
            st_next.lat_valid = 1'b1;
          end
        end else begin
          if (st_reg.ctl.hv_apply) begin
            st_next.fail = 1'b1;
          end
          if (st_reg.ctl.bus_latch_ctl) begin
            st_next.rsp.prdata = {24'h000000, st_reg.lat_data};
            if (!st_reg.ctl.hv_apply) begin
              st_next.lat_addr  = idx;
              st_next.lat_valid = 1'b1;
            end
          end else if (st_reg.ctl.array_power_off) begin
            st_next.rsp.prdata = '0;
          end else if (idx == IDX_NVR) begin
            st_next.rsp.prdata = {24'h000000, st_reg.nvr};
            st_next.load_pend  = 1'b1;
          end else begin
            off                = idx - IDX_ARRAY_LO;
            st_next.rsp.prdata = {24'h000000, st_reg.mem[off[8:0]]};
          end
        end
      end else if (idx == IDX_SHADOW) begin
        if (!apb_req.pwrite) begin
          st_next.rsp.prdata = {24'h000000, st_reg.shadow};
        end
      end else begin
        st_next.rsp.pslverr = 1'b1;
      end
    end

    // ************************************************************
    // array update at end of a good cycle
    // ************************************************************
    // a failed or powered-down cycle leaves the array untouched
    if (apply && !st_reg.fail && !st_reg.ctl.array_power_off &&
        op_allowed(st_reg.lat_addr, st_reg.ctl.erase_mode_sel, st_reg.shadow)) begin
      off = st_reg.lat_addr - IDX_ARRAY_LO;
      case (st_reg.ctl.erase_mode_sel)
        MODE_BYTE_PGM: begin
          if (st_reg.lat_addr == IDX_NVR) begin
            st_next.nvr = st_reg.nvr & st_reg.lat_data;
          end else begin
            st_next.mem[off[8:0]] = st_reg.mem[off[8:0]] & st_reg.lat_data;
          end
        end
        MODE_BYTE_ERASE: begin
          if (st_reg.lat_addr == IDX_NVR) begin
            st_next.nvr = ERASED_BYTE;
          end else begin
            st_next.mem[off[8:0]] = ERASED_BYTE;
          end
        end
        default: begin
          // nvr is never inside a block or bulk erase
          if (st_reg.lat_addr != IDX_NVR) begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
              if (st_reg.ctl.erase_mode_sel == MODE_BULK_ERASE ||
                  (i >> BLOCK_SHIFT) == int'(off[8:BLOCK_SHIFT])) begin
                st_next.mem[i] = ERASED_BYTE;
              end
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg           <= '0;
      st_reg.mem       <= {ARRAY_BYTES{ERASED_BYTE}};
      st_reg.nvr       <= NVR_FACTORY;
      st_reg.ctl       <= eepc_ctl_s'(CTL_RESET);
      st_reg.shadow    <= ERASED_BYTE;
      st_reg.load_pend <= 1'b1;
      st_reg.seq       <= SEQ_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign apb_rsp        = st_reg.rsp;
  assign charge_pump_on = st_reg.pump_on;

endmodule

// file: src/eepc_pkg.sv
package eepc_pkg;

  // ************************************************************
  // bus and address map (indices; byte address is four times)
  // ************************************************************
  localparam int          PADDR_W      = 18;
  localparam int          IDX_W        = 16;
  localparam logic [15:0] IDX_ARRAY_LO = 16'h0800;
  localparam logic [15:0] IDX_ARRAY_HI = 16'h09FF;
  localparam logic [15:0] IDX_SEC_LO   = 16'h08F0;
  localparam logic [15:0] IDX_SEC_HI   = 16'h08FF;
  localparam logic [15:0] IDX_NVR      = 16'hFE1C;
  localparam logic [15:0] IDX_CTL      = 16'hFE1D;
  localparam logic [15:0] IDX_SHADOW   = 16'hFE1F;

  // ************************************************************
  // array geometry and reset values
  // ************************************************************
  localparam int          ARRAY_BYTES  = 512;
  localparam int          BLOCK_SHIFT  = 7;
  localparam int          BLOCKS       = 4;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
  localparam logic [7:0]  NVR_FACTORY  = 8'h10;
  localparam logic [7:0]  CTL_RESET    = 8'h00;
  localparam int          SHADOW_SECURE = 4;

  // ************************************************************
  // mode codes
  // ************************************************************
  localparam logic [1:0]  MODE_BYTE_PGM   = 2'h0;
  localparam logic [1:0]  MODE_BYTE_ERASE = 2'h1;
  localparam logic [1:0]  MODE_BLOCK_ERASE = 2'h2;
  localparam logic [1:0]  MODE_BULK_ERASE = 2'h3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          AUTO_TIME_US = 5000;
  localparam int          AUTO_CYCLES_DEF = AUTO_TIME_US * (CLK_HZ / 1_000_000);

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic               spare_bit;
    logic               rsvd;
    logic               array_power_off;
    logic [1:0]         erase_mode_sel;
    logic               bus_latch_ctl;
    logic               auto_term;
    logic               hv_apply;
  } eepc_ctl_s;

  typedef struct packed {
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [31:0]        pwdata;
  } eepc_apb_req_s;

  typedef struct packed {
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } eepc_apb_rsp_s;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HALT} eepc_seq_e;

endpackage

// file: verification/eepc_checker_assertions.sv
module eepc_checker
  import eepc_pkg::*;
#(
  parameter int unsigned AUTO_CYCLES = AUTO_CYCLES_DEF
) (
  // clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // bus, power modes, pump
  input wire eepc_apb_req_s apb_req,
  input wire eepc_apb_rsp_s apb_rsp,
  input wire logic          wait_mode,
  input wire logic          stop_mode,
  input wire logic          charge_pump_on
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic        take;
  logic        arr;
  logic        mapped;
  logic        ctl_wr;
  logic [15:0] idx;
  logic [31:0] on_cnt;

  assign idx = apb_req.paddr[17:2];
  assign take = apb_req.psel & apb_req.penable & !apb_rsp.pready;
  assign arr = (idx >= IDX_ARRAY_LO && idx <= IDX_ARRAY_HI) || idx == IDX_NVR;
  assign mapped = arr || idx == IDX_CTL || idx == IDX_SHADOW;
  assign ctl_wr = take && apb_req.pwrite && idx == IDX_CTL;

  // cycles the pump has been on, to tie timer ends to the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_cnt <= '0;
    else on_cnt <= charge_pump_on ? on_cnt + 32'd1 : '0;
  end

  sequence s_take; take; endsequence
  sequence s_bad; take && !mapped; endsequence
  sequence s_halt_acc; stop_mode && take && arr; endsequence

  AST_ONE_WAIT: assert property (s_take |=> apb_rsp.pready)
    else $error("no ready one cycle after access");
  AST_READY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  AST_UNMAPPED: assert property (s_bad |=> apb_rsp.pslverr && apb_rsp.prdata == '0)
    else $error("unmapped access not refused");
  AST_UPPER_ZERO: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == '0)
    else $error("read data upper bits not zero");
  AST_PUMP_START: assert property ($rose(charge_pump_on) |->
    $past(ctl_wr && apb_req.pwdata[0]) || $past(stop_mode, 2) || $past(stop_mode, 3))
    else $error("pump on without program start");
  AST_PUMP_STOP: assert property ($fell(charge_pump_on) |->
    on_cnt == AUTO_CYCLES || $past(ctl_wr) || $past(stop_mode))
    else $error("pump off without cause");
  AST_STOP_HALT: assert property (stop_mode |=> !charge_pump_on)
    else $error("pump on during stop");
  AST_HALT_ERR: assert property (s_halt_acc |=> apb_rsp.pslverr)
    else $error("array access during stop not refused");
endmodule

bind eepc_eeprom_program_erase_control eepc_checker #(.AUTO_CYCLES(AUTO_CYCLES)) eepc_checker_i (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .wait_mode(wait_mode), .stop_mode(stop_mode), .charge_pump_on(charge_pump_on));

// file: verification/eepc_cpu_model.sv
module eepc_cpu_model
  import eepc_pkg::*;
(
  // clock
  input  wire logic          pclk,
  // bus
  output eepc_apb_req_s      apb_req,
  input  wire eepc_apb_rsp_s apb_rsp
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] rd;
  logic       err;

  initial apb_req = '0;

  // one whole transfer; an extra edge before return keeps back-to-back calls race free
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    apb_req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, d}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata[7:0];
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    // released lines stop showing the old value
    apb_req.pwdata <= ~apb_req.pwdata;
    @(posedge pclk);
  endtask
endmodule

// file: verification/tb_top.sv
module tb_top
  import eepc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // short timer keeps the run brief
  localparam int unsigned AC = 20;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          wait_mode = 1'b0;
  logic          stop_mode = 1'b0;
  logic          charge_pump_on;
  eepc_apb_req_s apb_req;
  eepc_apb_rsp_s apb_rsp;
  int            n_errors = 0;
  int            comparisons = 0;
  int            cycles = 0;

  always #50 pclk = ~pclk;

  eepc_eeprom_program_erase_control #(.AUTO_CYCLES(AC)) eepc_eeprom_program_erase_control_i (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .charge_pump_on(charge_pump_on));
  eepc_cpu_model eepc_cpu_model_i (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  // ********
  // helpers
  // ********
  task automatic end_of_test;
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    eepc_cpu_model_i.xfer(1'b1, i, d);
  endtask
  task automatic rdc(input string what, input logic [15:0] i, input logic [7:0] exp);
    eepc_cpu_model_i.xfer(1'b0, i, 8'h00);
    chk(what, eepc_cpu_model_i.rd, exp);
  endtask
  task automatic poll;
    int k;
    k = 0;
    do begin
      eepc_cpu_model_i.xfer(1'b0, IDX_CTL, 8'h00);
      k++;
    end while (eepc_cpu_model_i.rd[0] !== 1'b0 && k < 40);
    chk("hv_auto_clear", eepc_cpu_model_i.rd & 8'h01, 8'h00);
  endtask
  task automatic run(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d);
    wr(IDX_CTL, {3'h0, m, 3'h6});
    wr(a, d);
    wr(IDX_CTL, {3'h0, m, 3'h7});
    poll;
    wr(IDX_CTL, 8'h00);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset;
    rdc("ctl_rst", IDX_CTL, CTL_RESET);
    rdc("shadow_rst", IDX_SHADOW, NVR_FACTORY);
    rdc("blank", 16'h09FF, ERASED_BYTE);
    wr(IDX_CTL, 8'hA0);
    rdc("spare_off", IDX_CTL, 8'hA0);
    rdc("off_read", 16'h0800, 8'h00);
    wr(IDX_CTL, 8'h00);
    eepc_cpu_model_i.xfer(1'b0, 16'h1234, 8'h00);
    chk("unmapped_err", {7'h0, eepc_cpu_model_i.err}, 8'h01);
  endtask
  task automatic t_latch;
    wr(IDX_CTL, 8'h01);
    rdc("hv_no_latch", IDX_CTL, 8'h00);
    wr(IDX_CTL, 8'h06);
    wr(IDX_SHADOW, 8'h00);
    wr(IDX_CTL, 8'h87);
    rdc("ctl_blocked", IDX_CTL, 8'h06);
    chk("pump_idle", {7'h0, charge_pump_on}, 8'h00);
    wr(16'h0805, 8'h5A);
    wr(16'h0806, 8'hA5);
    rdc("latched_rd", 16'h0805, 8'hA5);
    wr(IDX_CTL, 8'h07);
    chk("pump_on", {7'h0, charge_pump_on}, 8'h01);
    poll;
    chk("pump_off", {7'h0, charge_pump_on}, 8'h00);
    wr(IDX_CTL, 8'h00);
    rdc("prog_addr", 16'h0805, 8'hA5);
    rdc("other_byte", 16'h0806, ERASED_BYTE);
  endtask
  task automatic t_program;
    wait_mode <= 1'b1;
    run(MODE_BYTE_PGM, 16'h0805, 8'h0F);
    wait_mode <= 1'b0;
    rdc("prog_and", 16'h0805, 8'h05);
  endtask
  task automatic t_manual;
    wr(IDX_CTL, 8'h04);
    wr(16'h0900, 8'h3C);
    wr(IDX_CTL, 8'h05);
    wr(IDX_CTL, 8'h1D);
    rdc("mode_frozen", IDX_CTL, 8'h05);
    wr(IDX_CTL, 8'h00);
    rdc("latch_kept", IDX_CTL, 8'h04);
    chk("pump_manual", {7'h0, charge_pump_on}, 8'h00);
    wr(IDX_CTL, 8'h00);
    rdc("latch_clr", IDX_CTL, 8'h00);
    rdc("manual_prog", 16'h0900, 8'h3C);
  endtask
  task automatic t_erase;
    run(MODE_BYTE_PGM, 16'h0880, 8'h00);
    run(MODE_BYTE_ERASE, 16'h0805, 8'h00);
    rdc("byte_erased", 16'h0805, ERASED_BYTE);
    rdc("byte_kept", 16'h0900, 8'h3C);
    run(MODE_BLOCK_ERASE, 16'h0980, 8'h00);
    rdc("blk_other", 16'h0900, 8'h3C);
    run(MODE_BLOCK_ERASE, 16'h097F, 8'h55);
    rdc("blk_erased", 16'h0900, ERASED_BYTE);
    rdc("blk_kept", 16'h0880, 8'h00);
    run(MODE_BULK_ERASE, 16'h09FF, 8'h00);
    rdc("bulk_erased", 16'h0880, ERASED_BYTE);
    rdc("nvr_kept", IDX_NVR, NVR_FACTORY);
  endtask
  task automatic t_stop;
    wr(IDX_CTL, 8'h06);
    wr(16'h0810, 8'h81);
    wr(IDX_CTL, 8'h07);
    stop_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("pump_halt", {7'h0, charge_pump_on}, 8'h00);
    eepc_cpu_model_i.xfer(1'b0, 16'h0810, 8'h00);
    chk("halt_err", {7'h0, eepc_cpu_model_i.err}, 8'h01);
    stop_mode <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("pump_resume", {7'h0, charge_pump_on}, 8'h01);
    poll;
    wr(IDX_CTL, 8'h00);
    rdc("after_stop", 16'h0810, 8'h81);
  endtask
  task automatic t_abort;
    wr(IDX_CTL, 8'h06);
    wr(16'h0811, 8'h00);
    stop_mode <= 1'b1;
    @(posedge pclk);
    stop_mode <= 1'b0;
    @(posedge pclk);
    wr(IDX_CTL, 8'h07);
    chk("pump_abort", {7'h0, charge_pump_on}, 8'h00);
    wr(16'h0811, 8'h00);
    wr(IDX_CTL, 8'h00);
    rdc("ctl_idle", IDX_CTL, 8'h00);
  endtask
  // an array read while high voltage is on spoils the cycle
  task automatic t_fail;
    wr(IDX_CTL, 8'h04);
    wr(16'h0820, 8'h00);
    wr(IDX_CTL, 8'h05);
    rdc("rd_in_hv", 16'h0820, 8'h00);
    wr(IDX_CTL, 8'h00);
    wr(IDX_CTL, 8'h00);
    rdc("fail_no_update", 16'h0820, ERASED_BYTE);
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test;
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_latch;
    t_program;
    t_manual;
    t_erase;
    t_stop;
    t_abort;
    t_fail;
    end_of_test;
  end
endmodule
